// ---- core/epd_pkg.sv ----
/*
 Shared constants and types for the execute packet dispatch block.
 Assumes a single 250 MHz clock and one fetch packet bus from program memory.
*/
package epd_pkg;
   localparam int FP_WIDTH    = 256;
   localparam int SLOT_WIDTH  = 32;
   localparam int SLOTS       = 8;
   localparam int SLOT_IDX_W  = 3;
   localparam int REG_COUNT   = 16;
   localparam int REG_IDX_W   = 4;
   localparam int UNITS       = 8;
   localparam int CHAIN_BIT   = 0;
   // ---------------------------------------------------------------
   // Instruction field layout
   // ---------------------------------------------------------------
   localparam int UNIT_LSB    = 1;
   localparam int UNIT_W      = 3;
   localparam int SIDE_BIT    = 4;
   localparam int XPATH_BIT   = 5;
   localparam int OPCLASS_LSB = 6;
   localparam int OPCLASS_W   = 3;
   localparam int SIZE_LSB    = 9;
   localparam int SIZE_W      = 2;
   localparam int AMODE_BIT   = 11;
   localparam int OFS_LONG_BIT= 12;
   localparam int DST_LSB     = 13;
   localparam int SRC_LSB     = 17;
   localparam int COND_LSB    = 28;
   localparam int COND_W      = 4;
   localparam int OFS_SHORT_W = 5;
   localparam int OFS_LONG_W  = 15;
   localparam int DW_WIDTH    = 64;
   localparam int DW_TOTAL    = 128;
   localparam logic [COND_W-1:0] COND_TRUE = 4'h0;

   // Unit index: side A units 0..3, side B units 4..7
   typedef enum logic [2:0] {
      EPD_LOGIC_A = 3'h0, EPD_SHIFT_A = 3'h1, EPD_MUL_A = 3'h2, EPD_DATA_A = 3'h3,
      EPD_LOGIC_B = 3'h4, EPD_SHIFT_B = 3'h5, EPD_MUL_B = 3'h6, EPD_DATA_B = 3'h7
   } epd_unit_t;

   typedef enum logic [2:0] {
      EPD_OP_ALU   = 3'h0, EPD_OP_MUL  = 3'h1, EPD_OP_BRANCH = 3'h2,
      EPD_OP_LOAD  = 3'h3, EPD_OP_STORE= 3'h4, EPD_OP_DWLOAD = 3'h5,
      EPD_OP_FLOAT = 3'h6, EPD_OP_NOP  = 3'h7
   } epd_opclass_t;

   typedef enum logic [1:0] {
      EPD_SZ_BYTE = 2'h0, EPD_SZ_HALF = 2'h1, EPD_SZ_WORD = 2'h2
   } epd_size_t;

   typedef enum logic [1:0] {
      EPD_IDLE  = 2'h0, EPD_WAIT = 2'h1, EPD_ISSUE = 2'h2
   } epd_state_t;
endpackage

// ---- core/epd_slot_check.sv ----
/*
 Per-instruction legality check: unit class against operation class.
 Assumes the slot word is already latched in the dispatch pipeline.
*/
`timescale 1ns/1ps
module epd_slot_check (
   input  wire logic [epd_pkg::SLOT_WIDTH-1:0] i_insn,
   output logic                                o_legal,
   output logic                                o_is_mem
);
   logic [epd_pkg::UNIT_W-1:0]    unit;
   logic [epd_pkg::OPCLASS_W-1:0] opc;
   logic [1:0]                    kind;

   always_comb begin
      unit = i_insn[epd_pkg::UNIT_LSB +: epd_pkg::UNIT_W];
      opc  = i_insn[epd_pkg::OPCLASS_LSB +: epd_pkg::OPCLASS_W];
      kind = unit[1:0];
      o_is_mem = 1'b0;
      o_legal  = 1'b0;
      unique case (opc)
         epd_pkg::EPD_OP_MUL:    o_legal = (kind == 2'h2);
         epd_pkg::EPD_OP_ALU,
         epd_pkg::EPD_OP_BRANCH: o_legal = (kind == 2'h0) || (kind == 2'h1);
         epd_pkg::EPD_OP_LOAD,
         epd_pkg::EPD_OP_STORE: begin
            o_legal  = (kind == 2'h3);
            o_is_mem = o_legal;
         end
         epd_pkg::EPD_OP_DWLOAD: begin
            o_legal  = (kind == 2'h1);
            o_is_mem = o_legal;
         end
         // floating point on logic, multiply, data
         epd_pkg::EPD_OP_FLOAT:  o_legal = (kind != 2'h1);
         epd_pkg::EPD_OP_NOP:    o_legal = 1'b1;
      endcase
   end
endmodule

// ---- core/epd_regfile.sv ----
/*
 One side's register file: sixteen 32-bit registers in flip-flops.
 Assumes the dispatcher grants at most one cross-side write per cycle.
*/
`timescale 1ns/1ps
module epd_regfile (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_sys_rst,
   input  wire logic [epd_pkg::UNITS-1:0]            i_wr_en,
   input  wire logic [epd_pkg::UNITS*epd_pkg::REG_IDX_W-1:0]  i_wr_idx,
   input  wire logic [epd_pkg::UNITS*epd_pkg::SLOT_WIDTH-1:0] i_wr_data,
   input  wire logic [epd_pkg::REG_IDX_W-1:0]        i_rd_idx,
   output logic      [epd_pkg::SLOT_WIDTH-1:0]       o_rd_data
);
   logic [epd_pkg::SLOT_WIDTH-1:0] regs      [epd_pkg::REG_COUNT];
   logic [epd_pkg::SLOT_WIDTH-1:0] next_regs [epd_pkg::REG_COUNT];

   // all unit writes in one cycle
   always_comb begin
      next_regs = regs;
      for (int u = 0; u < epd_pkg::UNITS; u++) begin
         if (i_wr_en[u]) begin
            next_regs[i_wr_idx[u*epd_pkg::REG_IDX_W +: epd_pkg::REG_IDX_W]] =
               i_wr_data[u*epd_pkg::SLOT_WIDTH +: epd_pkg::SLOT_WIDTH];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int r = 0; r < epd_pkg::REG_COUNT; r++) begin
            regs[r] <= '0;
         end
      end else begin
         regs <= next_regs;
      end
   end

   assign o_rd_data = regs[i_rd_idx];
endmodule

// ---- core/epd_dispatch.sv ----
/*
 Fetch and dispatch core: takes 256-bit fetch packets, splits them into
 execute packets by the chaining bit, issues one execute packet a cycle.
 Assumes program memory answers a fetch request with one valid pulse and
 that the program image keeps execute packets inside one fetch packet.
*/
// Operation
// - Fetch reads whole 256-bit eight-slot packets
// - Chain bit one joins next instruction
// - Chain bit zero ends execute packet
// - At most eight instructions per packet
// - Accept one to eight execute packets
// - Issue one execute packet per cycle
// - No fetch until packet fully dispatched
// - Two files of sixteen 32-bit registers
// - Four units per side, own file; code writes whichever file the side bit picks
// - Same-side file serves all units; code reads each file only for the other side's cross bus
// - One cross read, one write per side; code limits cross reads only, not writes
// - Float on L/M/D; shift does double-load
// - Only data units touch memory; code also marks double-word loads on shift units as memory
// - Linear or circular, 5/15-bit offsets
// - Every instruction conditional unless always-true
// - Multiplies only on multiply units
// - Byte, half-word and word granularity
`timescale 1ns/1ps
module epd_dispatch (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_sys_rst,
   input  wire logic                                 i_fp_valid,
   input  wire logic [epd_pkg::FP_WIDTH-1:0]         i_fp_data,
   input  wire logic [epd_pkg::REG_COUNT-1:0]        i_cond_a,
   input  wire logic [epd_pkg::REG_COUNT-1:0]        i_cond_b,
   input  wire logic [epd_pkg::UNITS*epd_pkg::SLOT_WIDTH-1:0] i_result,
   output logic                                      o_fp_req,
   output logic                                      o_ep_valid,
   output logic      [epd_pkg::UNITS-1:0]            o_unit_issue,
   output logic      [epd_pkg::UNITS*epd_pkg::SLOT_WIDTH-1:0] o_unit_insn,
   output logic      [epd_pkg::UNITS-1:0]            o_unit_mem,
   output logic      [epd_pkg::UNITS-1:0]            o_unit_circ,
   output logic      [epd_pkg::UNITS-1:0]            o_unit_long_ofs,
   output logic      [epd_pkg::UNITS*epd_pkg::SIZE_W-1:0] o_unit_size,
   output logic                                      o_conflict,
   output logic                                      o_illegal,
   output logic      [epd_pkg::SLOT_WIDTH-1:0]       o_xread_a,
   output logic      [epd_pkg::SLOT_WIDTH-1:0]       o_xread_b
);
   localparam int SW = epd_pkg::SLOT_WIDTH;
   localparam int UW = epd_pkg::UNITS;

   // ---------------------------------------------------------------
   // Fetch state
   // ---------------------------------------------------------------
   epd_pkg::epd_state_t                    state, next_state;
   logic [epd_pkg::FP_WIDTH-1:0]           fp, next_fp;
   logic [epd_pkg::SLOT_IDX_W-1:0]         ptr, next_ptr;
   logic                                   next_last_ep;
   logic [epd_pkg::SLOTS-1:0]              ep_mask;
   logic [epd_pkg::SLOTS-1:0]              slot_end;
   logic [epd_pkg::SLOTS-1:0]              legal;
   logic [epd_pkg::SLOTS-1:0]              is_mem;
   logic [epd_pkg::SLOTS-1:0]              cond_ok;

   // ---------------------------------------------------------------
   // Per-slot decode
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < epd_pkg::SLOTS; g++) begin : g_slot
         logic [SW-1:0]                        w;
         logic [epd_pkg::COND_W-1:0]           c;
         assign w = fp[g*SW +: SW];
         assign c = w[epd_pkg::COND_LSB +: epd_pkg::COND_W];
         // A stray chain bit in slot 7 must not run past the packet
         // last slot ends packet
         if (g == epd_pkg::SLOTS-1) begin : g_last
            assign slot_end[g] = 1'b1;
         end else begin : g_mid
            assign slot_end[g] = ~w[epd_pkg::CHAIN_BIT];
         end
         assign cond_ok[g] = (c == epd_pkg::COND_TRUE) ||
                             (w[epd_pkg::SIDE_BIT] ? i_cond_b[c] : i_cond_a[c]);
         epd_slot_check u_chk (
            .i_insn   (w),
            .o_legal  (legal[g]),
            .o_is_mem (is_mem[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Execute packet boundaries
   // ---------------------------------------------------------------
   // chain pulls following slots in
   always_comb begin
      logic done;
      done    = 1'b0;
      ep_mask = '0;
      for (int s = 0; s < epd_pkg::SLOTS; s++) begin
         if (s >= int'(ptr) && !done) begin
            ep_mask[s] = 1'b1;
            done       = slot_end[s];
         end
      end
   end

   // Next pointer is one past the packet end
   always_comb begin
      logic found;
      found        = 1'b0;
      next_last_ep = 1'b0;
      next_ptr     = ptr;
      next_state   = state;
      next_fp      = fp;
      for (int s = epd_pkg::SLOTS-1; s >= 0; s--) begin
         if (ep_mask[s] && !found) begin
            found        = 1'b1;
            next_last_ep = (s == epd_pkg::SLOTS-1);
            next_ptr     = epd_pkg::SLOT_IDX_W'(s + 1);
         end
      end
      unique case (state)
         // Single pass after reset; request rises on the same edge
         epd_pkg::EPD_IDLE: begin
            next_state = epd_pkg::EPD_WAIT;
            next_ptr   = ptr;
         end
         epd_pkg::EPD_WAIT: begin
            next_ptr = ptr;
            if (i_fp_valid) begin
               next_fp    = i_fp_data;
               next_ptr   = '0;
               next_state = epd_pkg::EPD_ISSUE;
            end
         end
         epd_pkg::EPD_ISSUE: begin
            if (next_last_ep) begin
               next_state = epd_pkg::EPD_WAIT;
               next_ptr   = '0;
            end
         end
         default: begin
            next_state = epd_pkg::EPD_IDLE;
            next_ptr   = '0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state   <= epd_pkg::EPD_IDLE;
         fp      <= '0;
         ptr     <= '0;
      end else begin
         state   <= next_state;
         fp      <= next_fp;
         ptr     <= next_ptr;
      end
   end

   // ---------------------------------------------------------------
   // Unit routing and cross-path check
   // ---------------------------------------------------------------
   logic [UW-1:0]         n_issue, n_mem, n_circ, n_long;
   logic [UW*SW-1:0]      n_insn;
   logic [UW*epd_pkg::SIZE_W-1:0] n_size;
   logic                  n_conflict, n_illegal, n_valid, n_req;
   logic [UW-1:0]         n_wen_a, n_wen_b;
   logic [UW*epd_pkg::REG_IDX_W-1:0] n_widx;

   always_comb begin
      logic [epd_pkg::UNIT_W-1:0] u;
      logic [SW-1:0]              w;
      logic [1:0]                 xr_a, xr_b;
      logic [UW-1:0]              used;
      u = '0;
      w = '0;
      xr_a = '0;
      xr_b = '0;
      used = '0;
      n_issue = '0; n_mem = '0; n_circ = '0; n_long = '0;
      n_insn = '0; n_size = '0; n_conflict = 1'b0; n_illegal = 1'b0;
      n_wen_a = '0; n_wen_b = '0; n_widx = '0;
      n_valid = (state == epd_pkg::EPD_ISSUE);
      // Decoded from next_state, so it rises and falls with the real wait
      // request only when packet drained
      n_req   = (next_state == epd_pkg::EPD_WAIT);
      for (int s = 0; s < epd_pkg::SLOTS; s++) begin
         w = fp[s*SW +: SW];
         u = w[epd_pkg::UNIT_LSB +: epd_pkg::UNIT_W];
         if (n_valid && ep_mask[s]) begin
            if (used[u] || !legal[s]) n_illegal = 1'b1;
            used[u] = 1'b1;
            if (w[epd_pkg::XPATH_BIT]) begin
               if (u[2]) xr_b = xr_b + 2'h1;
               else      xr_a = xr_a + 2'h1;
            end
            n_issue[u] = cond_ok[s];
            n_insn[u*SW +: SW] = w;
            n_mem[u]  = is_mem[s];
            n_circ[u] = w[epd_pkg::AMODE_BIT];
            n_long[u] = w[epd_pkg::OFS_LONG_BIT];
            n_size[u*epd_pkg::SIZE_W +: epd_pkg::SIZE_W] =
               w[epd_pkg::SIZE_LSB +: epd_pkg::SIZE_W];
         end
      end
      n_conflict = (xr_a > 2'h1) || (xr_b > 2'h1);
      if (n_conflict || n_illegal) n_issue = '0;
      // Write-back trails issue by a cycle; results must arrive then
      // units 0-3 side A, 4-7 side B
      // data unit loads may target either file
      for (int k = 0; k < UW; k++) begin
         n_widx[k*epd_pkg::REG_IDX_W +: epd_pkg::REG_IDX_W] =
            o_unit_insn[k*SW + epd_pkg::DST_LSB +: epd_pkg::REG_IDX_W];
         if (o_unit_issue[k]) begin
            if (o_unit_insn[k*SW + epd_pkg::SIDE_BIT]) n_wen_b[k] = 1'b1;
            else                                       n_wen_a[k] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_fp_req        <= 1'b0;
         o_ep_valid      <= 1'b0;
         o_unit_issue    <= '0;
         o_unit_insn     <= '0;
         o_unit_mem      <= '0;
         o_unit_circ     <= '0;
         o_unit_long_ofs <= '0;
         o_unit_size     <= '0;
         o_conflict      <= 1'b0;
         o_illegal       <= 1'b0;
      end else begin
         o_fp_req        <= n_req;
         o_ep_valid      <= n_valid;
         o_unit_issue    <= n_issue;
         o_unit_insn     <= n_insn;
         o_unit_mem      <= n_mem;
         o_unit_circ     <= n_circ;
         o_unit_long_ofs <= n_long;
         o_unit_size     <= n_size;
         o_conflict      <= n_conflict;
         o_illegal       <= n_illegal;
      end
   end

   // ---------------------------------------------------------------
   // Register files and cross reads
   // ---------------------------------------------------------------
   logic [SW-1:0] rd_a, rd_b;

   // Both files see every unit's write; the side bit picks the file
   // two sixteen-entry files
   epd_regfile u_rf_a (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_wr_en   (n_wen_a),
      .i_wr_idx  (n_widx),
      .i_wr_data (i_result),
      .i_rd_idx  (fp[epd_pkg::SRC_LSB +: epd_pkg::REG_IDX_W]),
      .o_rd_data (rd_a)
   );

   epd_regfile u_rf_b (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_wr_en   (n_wen_b),
      .i_wr_idx  (n_widx),
      .i_wr_data (i_result),
      .i_rd_idx  (fp[SW + epd_pkg::SRC_LSB +: epd_pkg::REG_IDX_W]),
      .o_rd_data (rd_b)
   );

   // Only slot 0 and slot 1 source fields reach the cross buses
   // single cross data bus each side
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_xread_a <= '0;
         o_xread_b <= '0;
      end else begin
         o_xread_a <= rd_b;
         o_xread_b <= rd_a;
      end
   end
endmodule

// ---- test/epd_dispatch_checker.sv ----
/*
 Checker for the dispatch block: fetch handshake, issue cadence, suppression
 of conflicting or illegal packets, routing of operations to units.
 Assumes it is bound to epd_dispatch and sees only that module's ports.
*/
`timescale 1ns/1ps
module epd_dispatch_checker (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_fp_valid,
   input  wire logic         o_fp_req,
   input  wire logic         o_ep_valid,
   input  wire logic [7:0]   o_unit_issue,
   input  wire logic [255:0] o_unit_insn,
   input  wire logic [7:0]   o_unit_mem,
   input  wire logic         o_conflict,
   input  wire logic         o_illegal
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // Units whose slot carries the given operation class
   function automatic logic [7:0] op_units(input logic [255:0] w, input logic [2:0] op);
      for (int k = 0; k < 8; k++) begin
         op_units[k] = (w[32*k+epd_pkg::OPCLASS_LSB +: 3] == op);
      end
   endfunction

   // ---------------------------------------------
   // Fetch handshake and issue cadence
   // ---------------------------------------------
   sequence s_take;
      o_fp_req && i_fp_valid;
   endsequence

   sequence s_first_issue;
      !o_fp_req ##1 o_ep_valid;
   endsequence

   a_req_drops: assert property (s_take |=> !o_fp_req)
      else $error("fetch request held after packet taken");
   a_first_issue: assert property (s_take |=> s_first_issue)
      else $error("first execute packet not issued two cycles after fetch");
   a_burst_runs: assert property (o_ep_valid && !o_fp_req |=> o_ep_valid)
      else $error("gap inside a fetch packet burst");
   a_idle_after: assert property (o_ep_valid && o_fp_req |=> !o_ep_valid)
      else $error("issue after last execute packet without a fetch");
   a_quiet_idle: assert property (!o_ep_valid |-> o_unit_issue == 8'h0)
      else $error("unit issued outside an execute packet");

   // ---------------------------------------------
   // Suppression and unit routing
   // ---------------------------------------------
   a_conflict_hold: assert property (o_conflict |-> o_unit_issue == 8'h0)
      else $error("issue despite cross path conflict");
   a_illegal_hold: assert property (o_illegal |-> o_unit_issue == 8'h0)
      else $error("issue despite illegal packet");
   a_mem_on_data: assert property ((o_unit_mem & o_unit_issue & 8'h77 &
      ~op_units(o_unit_insn, epd_pkg::EPD_OP_DWLOAD)) == 8'h0)
      else $error("memory operation issued on a non data unit");
   a_mul_on_mul: assert property (o_ep_valid |->
      (op_units(o_unit_insn, epd_pkg::EPD_OP_MUL) & o_unit_issue & 8'hbb) == 8'h0)
      else $error("multiply issued on a non multiply unit");
   a_dw_on_shift: assert property (o_ep_valid |->
      (op_units(o_unit_insn, epd_pkg::EPD_OP_DWLOAD) & o_unit_issue & 8'hdd) == 8'h0)
      else $error("double word load issued on a non shift unit");
endmodule

bind epd_dispatch epd_dispatch_checker i_epd_dispatch_checker (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fp_valid(i_fp_valid), .o_fp_req(o_fp_req),
   .o_ep_valid(o_ep_valid), .o_unit_issue(o_unit_issue), .o_unit_insn(o_unit_insn),
   .o_unit_mem(o_unit_mem), .o_conflict(o_conflict), .o_illegal(o_illegal)
);

// ---- test/epd_prog_mem.sv ----
/*
 Program memory model: answers each fetch request with one packet pulse.
 Assumes the bench loads the next packet image and the answer delay.
*/
`timescale 1ns/1ps
module epd_prog_mem (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_fp_req,
   input  wire logic         i_img_ready,
   input  wire logic [255:0] i_img,
   input  wire logic [3:0]   i_delay,
   output logic              o_fp_valid,
   output logic      [255:0] o_fp_data
);
   logic [3:0] wait_cnt;

   // Driven off the falling edge so the sampling edge sees it settled
   always @(negedge i_clk) begin
      if (i_sys_rst) begin
         o_fp_valid <= 1'b0;
         o_fp_data  <= 256'h0;
         wait_cnt   <= 4'h0;
      end else if (o_fp_valid) begin
         o_fp_valid <= 1'b0;
         // Released bus carries no stale packet
         o_fp_data  <= ~o_fp_data;
      end else if (i_fp_req && i_img_ready) begin
         if (wait_cnt == i_delay) begin
            o_fp_valid <= 1'b1;
            o_fp_data  <= i_img;
            wait_cnt   <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule

// ---- test/tb_top.sv ----
/*
 Testbench for the dispatch block: fetch packets of several shapes.
 Assumes the program memory model and the bound checker beside it.
*/
`timescale 1ns/1ps
module tb_top;
   logic         i_clk;
   logic         i_sys_rst;
   logic         fp_valid, fp_req, ep_valid, conflict, illegal, img_ready;
   logic [255:0] fp_data, result, unit_insn, img, first_insn;
   logic [15:0]  cond_a, cond_b, unit_size;
   logic [7:0]   unit_issue, unit_mem, unit_circ, unit_long;
   logic [31:0]  xread_a, xread_b;
   logic [3:0]   delay;
   logic [41:0]  cap [8];
   int           error_cnt, samples_checked;

   initial i_clk = 1'b0;
   always #2 i_clk = ~i_clk;

   epd_dispatch i_epd_dispatch (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fp_valid(fp_valid), .i_fp_data(fp_data),
      .i_cond_a(cond_a), .i_cond_b(cond_b), .i_result(result), .o_fp_req(fp_req),
      .o_ep_valid(ep_valid), .o_unit_issue(unit_issue), .o_unit_insn(unit_insn),
      .o_unit_mem(unit_mem), .o_unit_circ(unit_circ), .o_unit_long_ofs(unit_long),
      .o_unit_size(unit_size), .o_conflict(conflict), .o_illegal(illegal),
      .o_xread_a(xread_a), .o_xread_b(xread_b));

   epd_prog_mem i_epd_prog_mem (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fp_req(fp_req), .i_img_ready(img_ready),
      .i_img(img), .i_delay(delay), .o_fp_valid(fp_valid), .o_fp_data(fp_data));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ext is {long offset, circular, size}
   function automatic logic [31:0] mk(input logic [2:0] u, input logic [2:0] op,
                                      input logic [3:0] ext, input logic c);
      mk = {19'h0, ext, op, 1'b0, u[2], u, c};
   endfunction

   // Slot k on unit k with an operation that unit accepts
   function automatic logic [255:0] base(input logic [7:0] ch);
      for (int i = 0; i < 8; i++) begin
         base[32*i +: 32] = mk(i[2:0], (i % 4 == 2) ? epd_pkg::EPD_OP_MUL :
            (i % 4 == 3) ? epd_pkg::EPD_OP_LOAD : epd_pkg::EPD_OP_ALU, 4'h2, ch[i]);
      end
   endfunction

   // Supplies one packet and judges every execute packet that follows
   task automatic run_fp(input logic [255:0] p, input int n, input logic [63:0] m);
      int got;
      int t0;
      got = 0;
      t0 = 0;
      img <= p;
      img_ready <= 1'b1;
      for (int t = 0; t < 60 && got < n; t++) begin
         @(negedge i_clk);
         if (fp_valid === 1'b1) img_ready <= 1'b0;
         if (ep_valid === 1'b1) begin
            if (got == 0) t0 = t;
            if (got == 0) first_insn = unit_insn;
            check(t - t0, got);
            check(unit_issue, m[8*got +: 8]);
            check(fp_req, got == n - 1);
            cap[got] = {illegal, conflict, unit_size, unit_long, unit_circ, unit_mem};
            got++;
         end
      end
      @(negedge i_clk);
      check(ep_valid, 1'b0);
      if (got != n) begin
         error_cnt++;
         test_done();
      end
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_singles();
      delay <= 4'h3;
      run_fp(base(8'h00), 8, 64'h8040_2010_0804_0201);
      delay <= 4'h0;
   endtask

   task automatic t_chained();
      run_fp(base(8'hff), 1, 64'hff);
      check(first_insn, base(8'hff));
      run_fp(base(8'hfb), 2, 64'hf807);
   endtask

   task automatic t_illegal();
      logic [255:0] p;
      p = base(8'h00);
      p[31:0] = mk(3'h0, epd_pkg::EPD_OP_MUL, 4'h2, 1'b0);
      p[63:32] = mk(3'h0, epd_pkg::EPD_OP_ALU, 4'h2, 1'b1);
      p[95:64] = mk(3'h0, epd_pkg::EPD_OP_ALU, 4'h2, 1'b0);
      run_fp(p, 7, 64'h0080_4020_1008_0000);
      check({cap[0][41], cap[1][41], cap[2][41]}, 3'b110);
   endtask

   task automatic t_conflict();
      logic [255:0] p;
      p = base(8'h00);
      p[31:0] = mk(3'h0, epd_pkg::EPD_OP_ALU, 4'h2, 1'b1) | 32'h20;
      p[63:32] = mk(3'h1, epd_pkg::EPD_OP_ALU, 4'h2, 1'b0) | 32'h20;
      p[95:64] = mk(3'h4, epd_pkg::EPD_OP_ALU, 4'h2, 1'b1) | 32'h20;
      p[127:96] = mk(3'h0, epd_pkg::EPD_OP_ALU, 4'h2, 1'b0) | 32'h20;
      run_fp(p, 6, 64'h0000_8040_2010_1100);
      check({cap[0][40], cap[1][40]}, 2'b10);
   endtask

   task automatic t_memory();
      logic [255:0] p;
      p[31:0] = mk(3'h3, epd_pkg::EPD_OP_LOAD, 4'h4, 1'b1);
      p[63:32] = mk(3'h7, epd_pkg::EPD_OP_STORE, 4'h9, 1'b0);
      p[95:64] = mk(3'h1, epd_pkg::EPD_OP_DWLOAD, 4'h2, 1'b0);
      p[127:96] = mk(3'h7, epd_pkg::EPD_OP_LOAD, 4'he, 1'b0);
      p[159:128] = mk(3'h4, epd_pkg::EPD_OP_FLOAT, 4'h2, 1'b1);
      p[191:160] = mk(3'h5, epd_pkg::EPD_OP_ALU, 4'h2, 1'b1);
      p[223:192] = mk(3'h6, epd_pkg::EPD_OP_FLOAT, 4'h2, 1'b1);
      p[255:224] = mk(3'h2, epd_pkg::EPD_OP_MUL, 4'h2, 1'b1);
      run_fp(p, 4, 64'h7480_0288);
      check(cap[0] & {2'h3, 16'hc0c0, 24'hffffff}, {18'h4000, 24'h800888});
      check(cap[1][7:0], 8'h02);
      check(cap[2] & {2'h3, 16'hc000, 24'hffffff}, {18'h8000, 24'h808080});
   endtask

   task automatic t_cond();
      logic [255:0] p;
      cond_a <= 16'h0008;
      cond_b <= 16'h0004;
      p = base(8'h00) | 256'h3000_0000;
      p[63:32] = mk(3'h4, epd_pkg::EPD_OP_ALU, 4'h2, 1'b0) | 32'h5000_0000;
      p[95:64] = mk(3'h6, epd_pkg::EPD_OP_MUL, 4'h2, 1'b0) | 32'h2000_0000;
      run_fp(p, 8, 64'h8040_2010_0840_0001);
      cond_a <= 16'hffff;
      cond_b <= 16'hffff;
      check({xread_a, xread_b}, {2{32'ha5c3_0f96}});
   endtask

   // ---------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------
   initial begin
      i_sys_rst = 1'b1;
      img = 256'h0;
      img_ready = 1'b0;
      delay = 4'h0;
      cond_a = 16'hffff;
      cond_b = 16'hffff;
      result = {8{32'ha5c3_0f96}};
      error_cnt = 0;
      samples_checked = 0;
      repeat (12) @(negedge i_clk);
      check({fp_req, ep_valid, unit_issue}, 10'h0);
      i_sys_rst = 1'b0;
      @(negedge i_clk);
      check({fp_req, ep_valid}, 2'b10);
      @(negedge i_clk);
      check(fp_req, 1'b1);
      t_singles();
      t_chained();
      t_illegal();
      t_conflict();
      t_memory();
      t_cond();
      test_done();
   end

   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
endmodule
